// file: pkg/ifar_pkg.sv
package ifar_pkg;
	localparam int CW_W = 12;
	localparam int ROW_W = 8;
	localparam int ROWS = 256;
	localparam int BANKS = 4;
	localparam int SEL_W = 4;
	localparam int NREG = 16;
	localparam int ACC_W = 32;
	localparam int OUT_W = 16;
	localparam int WIN_W = 5;
	localparam int FIFO_DEPTH = 8;
	// Load record: address word then four data words
	localparam logic [2:0] PHASE_ADDR = 3'h0;
	localparam logic [2:0] PHASE_LAST = 3'h4;
	localparam logic [1:0] LAST_DATA = 2'h3;
	// Target decode on the upper address bits
	localparam logic [3:0] ADDR_COEF_HI = 4'h0;
	localparam logic [7:0] ADDR_ROUND_HI = 8'h80;
	localparam logic [7:0] ADDR_LIMIT_HI = 8'hc0;
	// Byte lane of a round or limit data word
	localparam int BYTE_W = 8;
	// Clamp field positions inside a limit register
	localparam int LOWER_LSB = 0;
	localparam int UPPER_LSB = 16;
	// Largest window select that maps onto the result
	localparam logic [4:0] WIN_MAX = 5'h10;
	localparam logic [31:0] ROUND_RST = 32'h0000_0000;
	localparam logic [31:0] LIMIT_RST = 32'h0000_0000;
	localparam logic [15:0] OUT_RST = 16'h0000;

	typedef struct packed {
		logic is_addr;
		logic [11:0] word;
	} ifar_ld_word_type;

	typedef enum logic [1:0] {
		TGT_NONE = 2'h0,
		TGT_COEF = 2'h1,
		TGT_ROUND = 2'h2,
		TGT_LIMIT = 2'h3
	} ifar_target_type;

	typedef enum logic [2:0] {
		DEC_WAIT = 3'b001,
		DEC_DATA = 3'b010,
		DEC_COMMIT = 3'b100
	} ifar_dec_state_type;
endpackage

// file: hw/ifar_top.sv
// Function
// - Control low: clear total, pass current sum
// - Control high: add new sum to total
// - Load enable low latches words on clock
// - Port armed only by falling load enable
// - Five words: one address, four data
// - Address decode: coefficients, round, limit ranges
// - Four 256x12 banks, words to banks 1-4
// - Banks written together after fourth word
// - Row select N picks coefficient set N
// - New row reaches multiplier registers on the second edge
// - Add selected 32-bit round register before window
// - Round register written after all four words
// - Byte per data word, least significant first
// - Round select N picks round register N
// - Sixteen-bit window of the 32-bit result
// - Clamp enable low clamps, high bypasses
// - Limit: lower bits 15-0, upper 31-16
// - Below lower gives lower, above upper gives upper
// - Limit register written after all four words
// - Limit select N picks limit register N
// - Limit words: lower two then upper two
// - Hold enable high keeps output register
`timescale 1ns/100ps

module ifar_fifo #(
	parameter int WIDTH = 13,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int PW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_r [0:DEPTH-1];
	logic [PW-1:0] wr_ptr_r, rd_ptr_r;
	logic [PW:0] count_r;
	logic do_push, do_pop;

	if (DEPTH < 2 || (1 << PW) != DEPTH || WIDTH < 1)
		$error("fifo depth must be a power of two of at least 2");

	assign in_ready = (count_r != DEPTH[PW:0]);
	assign out_valid = (count_r != '0);
	assign out_data = mem_r[rd_ptr_r];
	assign do_push = in_valid && in_ready;
	assign do_pop = out_valid && out_ready;

	always_ff @(posedge clk)
	begin
		if (do_push)
			mem_r[wr_ptr_r] <= in_data;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (do_push)
				wr_ptr_r <= wr_ptr_r + 1'b1;
			if (do_pop)
				rd_ptr_r <= rd_ptr_r + 1'b1;
			if (do_push && !do_pop)
				count_r <= count_r + 1'b1;
			else if (do_pop && !do_push)
				count_r <= count_r - 1'b1;
		end
	end

	fifo_count_a: assert property (@(posedge clk) disable iff (!rst_n)
		do_push && !do_pop |=> count_r == $past(count_r) + 1'b1)
		else $error("fifo count did not rise on push");
endmodule

module ifar_top #(
	parameter int FIFO_DEPTH = ifar_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic config_port_clock,
	input wire logic load_port_enable_n,
	input wire logic [ifar_pkg::CW_W-1:0] config_word_input,
	input wire logic [ifar_pkg::ROW_W-1:0] coefficient_row_select,
	input wire logic signed [ifar_pkg::ACC_W-1:0] products_sum,
	input wire logic sum_chain_control,
	input wire logic [ifar_pkg::SEL_W-1:0] round_register_select,
	input wire logic [ifar_pkg::WIN_W-1:0] output_window_select,
	input wire logic [ifar_pkg::SEL_W-1:0] limit_register_select,
	input wire logic clamp_enable_n,
	input wire logic output_hold_enable_n,
	output logic [ifar_pkg::BANKS-1:0][ifar_pkg::CW_W-1:0] coefficient_to_mult,
	output logic [ifar_pkg::OUT_W-1:0] filter_result_output,
	output logic load_overrun
);
	localparam int RW = $bits(ifar_pkg::ifar_ld_word_type);

	if (FIFO_DEPTH < 2)
		$error("FIFO_DEPTH too small");

	// Window of 16 bits starting at bit k; k above 16 saturates
	function automatic logic [15:0] window_of(input logic [31:0] v, input logic [4:0] k);
		logic [4:0] kk;
		logic [31:0] sh;
		kk = (k > ifar_pkg::WIN_MAX) ? ifar_pkg::WIN_MAX : k;
		sh = v >> kk;
		return sh[15:0];
	endfunction

	function automatic logic [15:0] clamp_of(input logic [15:0] v, input logic [31:0] lim);
		logic signed [15:0] lo, hi;
		lo = signed'(lim[ifar_pkg::LOWER_LSB +: 16]);
		hi = signed'(lim[ifar_pkg::UPPER_LSB +: 16]);
		if (signed'(v) < lo)
			return lo;
		else if (signed'(v) > hi)
			return hi;
		return v;
	endfunction

	// Link side: every pin from the host crosses two flops first
	logic config_port_clock_s1_r, config_port_clock_s2_r, config_port_clock_s3_r;
	logic ld_n_s1_r, ld_n_s2_r, ld_n_s3_r;
	logic [11:0] cw_s1_r, cw_s2_r;
	logic link_rise, ld_fall, armed_r, take_word, load_overrun_r;
	logic [2:0] phase_r;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			{config_port_clock_s1_r, config_port_clock_s2_r, config_port_clock_s3_r} <= 3'h0;
			// Reset to low so a low enable at power-up never arms
			{ld_n_s1_r, ld_n_s2_r, ld_n_s3_r} <= 3'h0;
			{cw_s1_r, cw_s2_r} <= 24'h000000;
		end
		else
		begin
			{config_port_clock_s1_r, config_port_clock_s2_r, config_port_clock_s3_r} <= {config_port_clock, config_port_clock_s1_r, config_port_clock_s2_r};
			{ld_n_s1_r, ld_n_s2_r, ld_n_s3_r} <= {load_port_enable_n, ld_n_s1_r, ld_n_s2_r};
			{cw_s1_r, cw_s2_r} <= {config_word_input, cw_s1_r};
		end
	end

	assign link_rise = config_port_clock_s2_r && !config_port_clock_s3_r;
	assign ld_fall = !ld_n_s2_r && ld_n_s3_r;

	// Arming needs a high-to-low edge; a high level disarms at once
	always_ff @(posedge clk)
	begin
		if (!rst_n || ld_n_s2_r)
			armed_r <= 1'b0;
		else if (ld_fall)
			armed_r <= 1'b1;
	end

	assign take_word = link_rise && !ld_n_s2_r && (armed_r || ld_fall);

	// Position within a record; wraps so addresses may chain
	always_ff @(posedge clk)
	begin
		if (!rst_n || ld_n_s2_r)
			phase_r <= ifar_pkg::PHASE_ADDR;
		else if (take_word)
		begin
			if (phase_r == ifar_pkg::PHASE_LAST)
				phase_r <= ifar_pkg::PHASE_ADDR;
			else
				phase_r <= phase_r + 3'h1;
		end
	end

	// Word buffer between link sampler and register writer
	ifar_pkg::ifar_ld_word_type push_word, pop_word;
	logic push_ready, pop_valid, pop_ready;

	assign push_word.is_addr = (phase_r == ifar_pkg::PHASE_ADDR);
	assign push_word.word = cw_s2_r;

	ifar_fifo #(
		.WIDTH(RW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(take_word),
		.in_ready(push_ready),
		.in_data(push_word),
		.out_valid(pop_valid),
		.out_ready(pop_ready),
		.out_data(pop_word)
	);

	// The link cannot be stalled, so a full buffer loses the word and says so
	always_ff @(posedge clk)
	begin
		if (!rst_n)
			load_overrun_r <= 1'b0;
		else if (take_word && !push_ready)
			load_overrun_r <= 1'b1;
		else if (ld_fall)
			load_overrun_r <= 1'b0;
	end

	assign load_overrun = load_overrun_r;

	// Register writer
	ifar_pkg::ifar_dec_state_type dec_state_r;
	ifar_pkg::ifar_target_type tgt_r;
	logic [7:0] tgt_idx_r;
	logic [1:0] dcnt_r;
	logic [11:0] dw_r [0:3];
	logic pop_fire;
	logic [31:0] packed_bytes;

	logic [11:0] bank_mem [0:ifar_pkg::BANKS-1][0:ifar_pkg::ROWS-1];
	logic [31:0] round_r [0:ifar_pkg::NREG-1];
	logic [31:0] limit_r [0:ifar_pkg::NREG-1];

	// Commit cycle stalls the buffer so each record lands whole
	assign pop_ready = (dec_state_r != ifar_pkg::DEC_COMMIT);
	assign pop_fire = pop_valid && pop_ready;
	assign packed_bytes = {dw_r[3][7:0], dw_r[2][7:0], dw_r[1][7:0], dw_r[0][7:0]};

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			dec_state_r <= ifar_pkg::DEC_WAIT;
			tgt_r <= ifar_pkg::TGT_NONE;
			tgt_idx_r <= '0;
			dcnt_r <= '0;
		end
		else
		begin
			case (dec_state_r)
				ifar_pkg::DEC_WAIT, ifar_pkg::DEC_DATA:
				begin
					if (pop_fire && pop_word.is_addr)
					begin
						dcnt_r <= '0;
						dec_state_r <= ifar_pkg::DEC_DATA;
						tgt_idx_r <= pop_word.word[7:0];
						if (pop_word.word[11:8] == ifar_pkg::ADDR_COEF_HI)
							tgt_r <= ifar_pkg::TGT_COEF;
						else if (pop_word.word[11:4] == ifar_pkg::ADDR_ROUND_HI)
							tgt_r <= ifar_pkg::TGT_ROUND;
						else if (pop_word.word[11:4] == ifar_pkg::ADDR_LIMIT_HI)
							tgt_r <= ifar_pkg::TGT_LIMIT;
						else
							tgt_r <= ifar_pkg::TGT_NONE;
					end
					else if (pop_fire && dec_state_r == ifar_pkg::DEC_DATA)
					begin
						dcnt_r <= dcnt_r + 2'h1;
						if (dcnt_r == ifar_pkg::LAST_DATA)
							dec_state_r <= ifar_pkg::DEC_COMMIT;
					end
				end
				default:
					dec_state_r <= ifar_pkg::DEC_WAIT;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (pop_fire && !pop_word.is_addr)
			dw_r[dcnt_r] <= pop_word.word;
	end

	// All four banks written in one cycle, never partially
	always_ff @(posedge clk)
	begin
		if (dec_state_r == ifar_pkg::DEC_COMMIT && tgt_r == ifar_pkg::TGT_COEF)
		begin
			for (int b = 0; b < ifar_pkg::BANKS; b++)
				bank_mem[b][tgt_idx_r] <= dw_r[b];
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < ifar_pkg::NREG; i++)
			begin
				round_r[i] <= ifar_pkg::ROUND_RST;
				limit_r[i] <= ifar_pkg::LIMIT_RST;
			end
		end
		else if (dec_state_r == ifar_pkg::DEC_COMMIT)
		begin
			if (tgt_r == ifar_pkg::TGT_ROUND)
				round_r[tgt_idx_r[3:0]] <= packed_bytes;
			else if (tgt_r == ifar_pkg::TGT_LIMIT)
				limit_r[tgt_idx_r[3:0]] <= packed_bytes;
		end
	end

	// Coefficient path to the multipliers
	logic [7:0] row_r;
	logic [ifar_pkg::BANKS-1:0][11:0] coef_r;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			row_r <= '0;
		else
			row_r <= coefficient_row_select;
	end

	always_ff @(posedge clk)
	begin
		for (int b = 0; b < ifar_pkg::BANKS; b++)
			coef_r[b] <= bank_mem[b][row_r];
	end

	assign coefficient_to_mult = coef_r;

	// Back end: accumulate, round, window, clamp, register
	logic [31:0] acc_r, rounded;
	logic [15:0] windowed, clamped, out_r;

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			acc_r <= '0;
		else if (!sum_chain_control)
			acc_r <= products_sum;
		else
			acc_r <= acc_r + products_sum;
	end

	// Round register is added at full width so any offset works
	assign rounded = acc_r + round_r[round_register_select];
	assign windowed = window_of(rounded, output_window_select);
	assign clamped = clamp_enable_n ? windowed
		: clamp_of(windowed, limit_r[limit_register_select]);

	always_ff @(posedge clk)
	begin
		if (!rst_n)
			out_r <= ifar_pkg::OUT_RST;
		else if (!output_hold_enable_n)
			out_r <= clamped;
	end

	assign filter_result_output = out_r;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);

	acc_clear_a: assert property (!sum_chain_control |=> acc_r == $past(products_sum))
		else $error("accumulator not cleared");
	acc_add_a: assert property (sum_chain_control |=>
		acc_r == $past(acc_r) + $past(products_sum))
		else $error("accumulator did not add");
	load_blocked_a: assert property (ld_n_s2_r |-> !take_word)
		else $error("word taken while load disabled");
	arm_edge_a: assert property (take_word |-> armed_r || $fell(ld_n_s2_r))
		else $error("word taken without arming edge");
	record_len_a: assert property (dec_state_r == ifar_pkg::DEC_COMMIT |->
		$past(dcnt_r) == ifar_pkg::LAST_DATA && $past(pop_fire))
		else $error("commit without four data words");
	bank_write_a: assert property (dec_state_r == ifar_pkg::DEC_COMMIT
		&& tgt_r == ifar_pkg::TGT_COEF |=> bank_mem[3][$past(tgt_idx_r)] == $past(dw_r[3]))
		else $error("coefficient row not written");
	round_write_a: assert property (dec_state_r == ifar_pkg::DEC_COMMIT
		&& tgt_r == ifar_pkg::TGT_ROUND |=> round_r[$past(tgt_idx_r[3:0])] == $past(packed_bytes))
		else $error("round register not written");
	row_latch_a: assert property ($changed(row_r) |=>
		coef_r[0] == $past(bank_mem[0][row_r]))
		else $error("coefficient not latched from row");
	window_pos_a: assert property (output_window_select <= ifar_pkg::WIN_MAX |->
		windowed == rounded[output_window_select +: 16])
		else $error("window misplaced");
	clamp_range_a: assert property (!clamp_enable_n
		&& signed'(windowed) < signed'(limit_r[limit_register_select][15:0])
		|-> clamped == limit_r[limit_register_select][15:0])
		else $error("lower limit not applied");
	out_hold_a: assert property (output_hold_enable_n |=> $stable(out_r))
		else $error("output changed while held");
	out_load_a: assert property (!output_hold_enable_n |=> out_r == $past(clamped))
		else $error("output not loaded");
endmodule

// file: sim/ifar_host.sv
`timescale 1ns/100ps
module ifar_host (
	output logic config_port_clock,
	output logic load_port_enable_n,
	output logic [11:0] config_word_input
);
	initial
	begin
		config_port_clock = 1'b0;
		load_port_enable_n = 1'b1;
		config_word_input = 12'h000;
	end
	// Load clock runs only inside put_word, standing low between frames
	task automatic put_word(input logic [11:0] w);
		config_word_input = w;
		#80 config_port_clock = 1'b1;
		#80 config_port_clock = 1'b0;
	endtask
	// Long high time so the synchronised enable is seen high before the fall
	task automatic arm();
		#200 load_port_enable_n = 1'b0;
		#100;
	endtask
	// Released word lines show the inverse, not the last value
	task automatic disarm();
		#40 load_port_enable_n = 1'b1;
		config_word_input = ~config_word_input;
	endtask
	// Address then n data words; a short n makes an incomplete record
	task automatic send(input logic [11:0] addr, input logic [47:0] v, input logic coef,
		input int n);
		put_word(addr);
		for (int k = 0; k < n; k++)
			put_word(coef ? v[12*k +: 12] : {4'h0, v[8*k +: 8]});
	endtask
endmodule

// file: sim/ifar_top_tb.sv
`timescale 1ns/100ps
module ifar_top_tb;
	typedef struct packed {
		logic [31:0] p;
		logic [3:0] rs;
		logic [4:0] win;
		logic [3:0] ls;
		logic cn;
		logic [15:0] exp;
	} ifar_row_type;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic config_port_clock;
	logic load_port_enable_n;
	logic [11:0] config_word_input;
	logic [7:0] coefficient_row_select = 8'h00;
	logic [31:0] products_sum = 32'h0000_0000;
	logic sum_chain_control = 1'b0;
	logic [3:0] round_register_select = 4'h0;
	logic [4:0] output_window_select = 5'h00;
	logic [3:0] limit_register_select = 4'h0;
	logic clamp_enable_n = 1'b1;
	logic output_hold_enable_n = 1'b0;
	logic [3:0][11:0] coefficient_to_mult;
	logic [15:0] filter_result_output;
	logic load_overrun;
	int failures = 0;
	int checks = 0;
	int cycles = 0;
	ifar_row_type rows [10];

	always #10 clk = ~clk;

	ifar_host ifar_host_inst (
		.config_port_clock(config_port_clock),
		.load_port_enable_n(load_port_enable_n),
		.config_word_input(config_word_input)
	);

	ifar_top #(.FIFO_DEPTH(8)) ifar_top_inst (
		.clk(clk),
		.rst_n(rst_n),
		.config_port_clock(config_port_clock),
		.load_port_enable_n(load_port_enable_n),
		.config_word_input(config_word_input),
		.coefficient_row_select(coefficient_row_select),
		.products_sum(products_sum),
		.sum_chain_control(sum_chain_control),
		.round_register_select(round_register_select),
		.output_window_select(output_window_select),
		.limit_register_select(limit_register_select),
		.clamp_enable_n(clamp_enable_n),
		.output_hold_enable_n(output_hold_enable_n),
		.coefficient_to_mult(coefficient_to_mult),
		.filter_result_output(filter_result_output),
		.load_overrun(load_overrun)
	);

	task automatic chk(input string name, input logic [47:0] exp, input logic [47:0] got);
		checks++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic drive(input logic [31:0] p, input logic ctl);
		@(posedge clk);
		products_sum <= p;
		sum_chain_control <= ctl;
	endtask

	// Result is due two edges after the sum enters
	task automatic apply(input ifar_row_type r);
		drive(r.p, 1'b0);
		round_register_select <= r.rs;
		output_window_select <= r.win;
		limit_register_select <= r.ls;
		clamp_enable_n <= r.cn;
		repeat (2) @(posedge clk);
		#1 chk("result", {32'h0, r.exp}, {32'h0, filter_result_output});
	endtask

	always @(posedge clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 20000)
		begin
			failures++;
			end_of_test();
		end
	end

	initial
	begin
		rows = '{
			'{32'h0001_2345, 4'h0, 5'h04, 4'h0, 1'b1, 16'h1234},
			'{32'h1234_5678, 4'h0, 5'h10, 4'h0, 1'b1, 16'h1234},
			'{32'h1234_5678, 4'h0, 5'h1f, 4'h0, 1'b1, 16'h1234},
			'{32'h0000_01c0, 4'h5, 5'h08, 4'h0, 1'b1, 16'h0002},
			'{32'h0000_0005, 4'h0, 5'h00, 4'h3, 1'b0, 16'h0123},
			'{32'h0000_7ff0, 4'h0, 5'h00, 4'h3, 1'b0, 16'h7fed},
			'{32'h0000_1000, 4'h0, 5'h00, 4'h3, 1'b0, 16'h1000},
			'{32'h0000_7ff0, 4'h0, 5'h00, 4'h3, 1'b1, 16'h7ff0},
			'{32'hffff_ffc0, 4'h0, 5'h00, 4'hf, 1'b0, 16'hffe0},
			'{32'h0001_2345, 4'h0, 5'h00, 4'h0, 1'b1, 16'h2345}};
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		#1 chk("reset output", 48'h0, {32'h0, filter_result_output});
		chk("reset overrun", 48'h0, {47'h0, load_overrun});
		ifar_host_inst.arm();
		ifar_host_inst.send(12'h00a, 48'h123_456_789_abc, 1'b1, 4);
		ifar_host_inst.send(12'h800, 48'h0, 1'b0, 4);
		ifar_host_inst.send(12'h805, 48'h80, 1'b0, 4);
		ifar_host_inst.send(12'hc03, 48'h7fed_0123, 1'b0, 4);
		ifar_host_inst.send(12'hc0f, 48'h0020_ffe0, 1'b0, 4);
		ifar_host_inst.disarm();
		repeat (20) @(posedge clk);
		coefficient_row_select <= 8'h0a;
		repeat (3) @(posedge clk);
		#1 chk("coefficients", 48'h123_456_789_abc, coefficient_to_mult);
		foreach (rows[i])
			apply(rows[i]);
		drive(32'h3, 1'b0);
		drive(32'h4, 1'b1);
		drive(32'h5, 1'b1);
		#1 chk("sum", 48'h3, {32'h0, filter_result_output});
		drive(32'h1, 1'b0);
		#1 chk("sum", 48'h7, {32'h0, filter_result_output});
		@(posedge clk);
		#1 chk("sum", 48'hc, {32'h0, filter_result_output});
		@(posedge clk);
		#1 chk("sum", 48'h1, {32'h0, filter_result_output});
		@(posedge clk);
		output_hold_enable_n <= 1'b1;
		drive(32'h7777, 1'b0);
		repeat (3) @(posedge clk);
		#1 chk("held", 48'h1, {32'h0, filter_result_output});
		@(posedge clk);
		output_hold_enable_n <= 1'b0;
		@(posedge clk);
		#1 chk("released", 48'h7777, {32'h0, filter_result_output});
		// Cut-short records and words sent while disabled must change nothing
		ifar_host_inst.arm();
		ifar_host_inst.send(12'h805, 48'hff, 1'b0, 2);
		ifar_host_inst.disarm();
		ifar_host_inst.arm();
		ifar_host_inst.send(12'hc03, 48'h0, 1'b0, 3);
		ifar_host_inst.disarm();
		ifar_host_inst.send(12'h805, 48'h0, 1'b0, 4);
		repeat (20) @(posedge clk);
		apply(rows[3]);
		apply(rows[4]);
		chk("overrun", 48'h0, {47'h0, load_overrun});
		end_of_test();
	end
endmodule
